//--- srp_serial_register_port.sv
// serial register port: host-clocked frame decoder, register store, pin drivers
// assumes the host runs the serial clock only inside frames and keeps it low while idle;
// the rest of the device sees writes and the four-wire select in the system clock domain
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.svh"

module srp_serial_register_port (
    // system clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // serial link from the host
    input wire logic i_sclk,
    input wire logic i_frame_select_n,
    input wire logic i_sdio,
    // bidirectional data pin drive
    output logic o_sdio,
    output logic o_sdio_oe,
    // dedicated serial output pin drive
    output logic o_serial_out_pin,
    output logic o_serial_out_pin_oe,
    // register write events in the system domain
    output logic o_wr_valid,
    output srp_pkg::srp_addr_type o_wr_addr,
    output srp_pkg::srp_word_type o_wr_data,
    // system-side read of the register mirror
    input wire srp_pkg::srp_addr_type i_rd_addr,
    output srp_pkg::srp_word_type o_rd_data,
    // mode seen by the rest of the device
    output logic o_four_wire_select
);
    // link-domain state
    srp_pkg::srp_cnt_type bit_cnt_q;
    srp_pkg::srp_cnt_type bit_cnt_d;
    logic [`SRP_WORD_W-1:0] shift_q;
    logic [`SRP_RW_BIT:0] instr_q;
    srp_pkg::srp_word_type regs_q [`SRP_NUM_REGS];
    srp_pkg::srp_word_type out_sh_q;
    logic frame_rst;
    logic four_wire_select;
    logic rd_flag;
    srp_pkg::srp_addr_type register_address_field;
    srp_pkg::srp_word_type wr_word;
    logic wr_fire;
    logic wr_tog_q;
    srp_pkg::srp_addr_type wr_addr_q;
    srp_pkg::srp_word_type wr_data_q;

    // system-domain state
    logic fw_s1_q;
    logic fw_s2_q;
    srp_pkg::srp_word_type mirror_q [`SRP_NUM_REGS];
    logic cdc_valid;
    srp_pkg::srp_addr_type cdc_addr;
    srp_pkg::srp_word_type cdc_data;

    srp_wr_if wr_if ();

    // frame logic is cleared by deselect, so nothing relies on a clock edge outside a frame
    assign frame_rst = i_rst | i_frame_select_n;

    // fields of the received instruction byte
    assign rd_flag = instr_q[`SRP_RW_BIT];
    assign register_address_field = instr_q[`SRP_ADDR_MSB:0];

    // mode bit read straight from the settings register
    assign four_wire_select = regs_q[`SRP_SETTINGS_TWO_ADDR][`SRP_FOUR_WIRE_BIT];

    // completed data word, upper byte shifted in first
    assign wr_word = {shift_q[`SRP_WORD_W-2:0], i_sdio};
    assign wr_fire = (bit_cnt_q == `SRP_CNT_DATA_LAST) && !rd_flag;

    // bit counter saturates after the two data bytes; extra clocks are ignored
    always_comb begin
        bit_cnt_d = bit_cnt_q;
        if (bit_cnt_q != `SRP_CNT_END) begin
            bit_cnt_d = bit_cnt_q + `SRP_CNT_ONE;
        end
    end

    // rising-edge sampling of the input pin
    always_ff @(posedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_q <= `SRP_CNT_ZERO;
            shift_q <= `SRP_REG_RESET;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            shift_q <= {shift_q[`SRP_WORD_W-2:0], i_sdio};
        end
    end

    // instruction byte captured on its eighth rising edge, kept for the frame
    always_ff @(posedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            instr_q <= `SRP_INSTR_RESET;
        end else if (bit_cnt_q == `SRP_CNT_INSTR_LAST) begin
            instr_q <= {shift_q[`SRP_RW_BIT-1:0], i_sdio};
        end
    end

    // register store; survives frames, cleared only by the device reset
    generate
        for (genvar g = 0; g < `SRP_NUM_REGS; g++) begin : g_reg
            always_ff @(posedge i_sclk or posedge i_rst) begin
                if (i_rst) begin
                    regs_q[g] <= `SRP_REG_RESET;
                end else if (wr_fire && (register_address_field == srp_pkg::srp_addr_type'(g))) begin
                    regs_q[g] <= wr_word;
                end
            end
        end
    endgenerate

    // write event held for the crossing; toggles once per completed write
    always_ff @(posedge i_sclk or posedge i_rst) begin
        if (i_rst) begin
            wr_tog_q <= `SRP_BIT_RESET;
            wr_addr_q <= `SRP_ADDR_RESET;
            wr_data_q <= `SRP_REG_RESET;
        end else if (wr_fire) begin
            wr_tog_q <= ~wr_tog_q;
            wr_addr_q <= register_address_field;
            wr_data_q <= wr_word;
        end
    end

    assign wr_if.tog = wr_tog_q;
    assign wr_if.addr = wr_addr_q;
    assign wr_if.data = wr_data_q;

    // falling-edge read shifter: loads after the instruction byte, then shifts msb first
    always_ff @(negedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            out_sh_q <= `SRP_REG_RESET;
        end else if (rd_flag) begin
            if (bit_cnt_q == `SRP_CNT_DATA_FIRST) begin
                out_sh_q <= {regs_q[register_address_field][`SRP_WORD_W-2:0], 1'h0};
            end else begin
                out_sh_q <= {out_sh_q[`SRP_WORD_W-2:0], 1'h0};
            end
        end
    end

    // falling-edge pin drivers; deselect floats both pins at once
    always_ff @(negedge i_sclk or posedge frame_rst) begin
        if (frame_rst) begin
            o_sdio <= `SRP_BIT_RESET;
            o_sdio_oe <= `SRP_BIT_RESET;
            o_serial_out_pin <= `SRP_BIT_RESET;
            o_serial_out_pin_oe <= `SRP_BIT_RESET;
        end else if (rd_flag && (bit_cnt_q == `SRP_CNT_END)) begin
            // read finished: both pins low until frame select rises
            o_sdio <= 1'h0;
            o_sdio_oe <= 1'h1;
            o_serial_out_pin <= 1'h0;
            o_serial_out_pin_oe <= 1'h1;
        end else if (rd_flag && (bit_cnt_q >= `SRP_CNT_DATA_FIRST)) begin
            // data phase: drive only after the full instruction byte
            if (bit_cnt_q == `SRP_CNT_DATA_FIRST) begin
                o_sdio <= regs_q[register_address_field][`SRP_WORD_W-1];
                o_serial_out_pin <= regs_q[register_address_field][`SRP_WORD_W-1];
            end else begin
                o_sdio <= out_sh_q[`SRP_WORD_W-1];
                o_serial_out_pin <= out_sh_q[`SRP_WORD_W-1];
            end
            o_sdio_oe <= !four_wire_select;
            o_serial_out_pin_oe <= four_wire_select;
        end else begin
            // instruction phase or write: data pin stays an input
            o_sdio <= 1'h0;
            o_sdio_oe <= 1'h0;
            o_serial_out_pin <= 1'h0;
            o_serial_out_pin_oe <= 1'h0;
        end
    end

    // write events into the system domain
    srp_wr_cdc u_wr_cdc (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .wr(wr_if.dst),
        .o_valid(cdc_valid),
        .o_addr(cdc_addr),
        .o_data(cdc_data)
    );

    // registered write event outputs
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wr_valid <= `SRP_BIT_RESET;
            o_wr_addr <= `SRP_ADDR_RESET;
            o_wr_data <= `SRP_REG_RESET;
        end else begin
            o_wr_valid <= cdc_valid;
            o_wr_addr <= cdc_addr;
            o_wr_data <= cdc_data;
        end
    end

    // system-side copy of the register store, fed by crossed writes
    generate
        for (genvar m = 0; m < `SRP_NUM_REGS; m++) begin : g_mirror
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    mirror_q[m] <= `SRP_REG_RESET;
                end else if (cdc_valid && (cdc_addr == srp_pkg::srp_addr_type'(m))) begin
                    mirror_q[m] <= cdc_data;
                end
            end
        end
    endgenerate

    // registered mirror read port
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data <= `SRP_REG_RESET;
        end else begin
            o_rd_data <= mirror_q[i_rd_addr];
        end
    end

    // four-wire select level brought into the system domain
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            fw_s1_q <= `SRP_BIT_RESET;
            fw_s2_q <= `SRP_BIT_RESET;
            o_four_wire_select <= `SRP_BIT_RESET;
        end else begin
            fw_s1_q <= four_wire_select;
            fw_s2_q <= fw_s1_q;
            o_four_wire_select <= fw_s2_q;
        end
    end
endmodule : srp_serial_register_port

`default_nettype wire

//--- srp_defines.svh
// constants for the serial register port: field positions, counts, reset values
// assumes inclusion by bare name from every file of the block
`ifndef SRP_DEFINES_SVH
`define SRP_DEFINES_SVH

// word, address and counter widths, register count
`define SRP_ADDR_W 7
`define SRP_WORD_W 16
`define SRP_CNT_W 5
`define SRP_NUM_REGS 128

// instruction byte layout
`define SRP_RW_BIT 7
`define SRP_ADDR_MSB 6

// bit counter milestones
`define SRP_CNT_INSTR_LAST 5'h07
`define SRP_CNT_DATA_FIRST 5'h08
`define SRP_CNT_DATA_LAST 5'h17
`define SRP_CNT_END 5'h18
`define SRP_CNT_ONE 5'h01
`define SRP_CNT_ZERO 5'h00

// register holding the four-wire select bit
`define SRP_SETTINGS_TWO_ADDR 7'h02
`define SRP_FOUR_WIRE_BIT 0

// reset values
`define SRP_REG_RESET 16'h0000
`define SRP_ADDR_RESET 7'h00
`define SRP_BIT_RESET 1'h0
`define SRP_INSTR_RESET 8'h00

`endif

//--- srp_pkg.sv
// types shared by the serial register port modules
// assumes srp_defines.svh for widths
`default_nettype none
`include "srp_defines.svh"

package srp_pkg;
    typedef logic [`SRP_ADDR_W-1:0] srp_addr_type;
    typedef logic [`SRP_WORD_W-1:0] srp_word_type;
    typedef logic [`SRP_CNT_W-1:0] srp_cnt_type;
endpackage : srp_pkg

`default_nettype wire

//--- srp_wr_if.sv
// write event carrier from the serial-clock side to the system-clock side
// assumes the source holds addr and data stable from a toggle until the next one
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.svh"

interface srp_wr_if;
    logic tog;
    srp_pkg::srp_addr_type addr;
    srp_pkg::srp_word_type data;

    modport src (output tog, output addr, output data);
    modport dst (input tog, input addr, input data);
endinterface : srp_wr_if

`default_nettype wire

//--- srp_wr_cdc.sv
// toggle crossing of register write events into the system clock domain
// assumes addr and data are stable for many system clocks after each toggle
`timescale 1ns/1ps
`default_nettype none
`include "srp_defines.svh"

module srp_wr_cdc (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // crossing source
    srp_wr_if.dst wr,
    // system side event
    output logic o_valid,
    output srp_pkg::srp_addr_type o_addr,
    output srp_pkg::srp_word_type o_data
);
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_s3_q;

    // two-flop synchroniser plus history flop for edge detection
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tog_s1_q <= `SRP_BIT_RESET;
            tog_s2_q <= `SRP_BIT_RESET;
            tog_s3_q <= `SRP_BIT_RESET;
        end else begin
            tog_s1_q <= wr.tog;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    // one-cycle event with its word, captured once the toggle is seen
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_valid <= `SRP_BIT_RESET;
            o_addr <= `SRP_ADDR_RESET;
            o_data <= `SRP_REG_RESET;
        end else begin
            o_valid <= tog_s2_q ^ tog_s3_q;
            if (tog_s2_q ^ tog_s3_q) begin
                o_addr <= wr.addr;
                o_data <= wr.data;
            end
        end
    end
endmodule : srp_wr_cdc

`default_nettype wire

//--- srp_monitor.sv
// checker on the serial register port pins and write events
// assumes binding to the top module ports
`timescale 1ns/1ps
`default_nettype none
module srp_monitor (
    // clocks and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // serial link
    input wire logic i_sclk,
    input wire logic i_frame_select_n,
    input wire logic i_sdio,
    // pin drives
    input wire logic o_sdio,
    input wire logic o_sdio_oe,
    input wire logic o_serial_out_pin,
    input wire logic o_serial_out_pin_oe,
    // system side
    input wire logic o_wr_valid,
    input wire logic o_four_wire_select
);
    logic [4:0] cnt_q;
    logic rd_q;
    logic wr_done;
    // rises seen in this frame and the read flag
    always_ff @(posedge i_sclk or posedge i_frame_select_n) begin
        if (i_frame_select_n) begin
            cnt_q <= 5'h00;
            rd_q <= 1'b0;
        end else begin
            if (cnt_q != 5'h18)
                cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h00)
                rd_q <= i_sdio;
        end
    end
    assign wr_done = (cnt_q == 5'h18) && !rd_q;
    property p_instr_quiet;
        @(posedge i_sclk) disable iff (i_rst || i_frame_select_n)
        cnt_q < 5'h08 |-> !o_sdio_oe && !o_serial_out_pin_oe;
    endproperty
    a_instr_quiet: assert property (p_instr_quiet) else $error("pin driven in instruction byte");
    property p_write_quiet;
        @(posedge i_sclk) disable iff (i_rst || i_frame_select_n)
        cnt_q != 5'h00 && !rd_q |-> !o_sdio_oe && !o_serial_out_pin_oe;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("pin driven in write");
    property p_read3;
        @(posedge i_sclk) disable iff (i_rst || i_frame_select_n)
        rd_q && cnt_q inside {[5'h08:5'h17]} && !o_four_wire_select |-> o_sdio_oe && !o_serial_out_pin_oe;
    endproperty
    a_read3: assert property (p_read3) else $error("three wire read pins wrong");
    property p_read4;
        @(posedge i_sclk) disable iff (i_rst || i_frame_select_n)
        rd_q && cnt_q inside {[5'h08:5'h17]} && o_four_wire_select |-> o_serial_out_pin_oe && !o_sdio_oe;
    endproperty
    a_read4: assert property (p_read4) else $error("four wire read pins wrong");
    property p_deselect_float;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_frame_select_n |-> !o_sdio_oe && !o_serial_out_pin_oe;
    endproperty
    a_deselect_float: assert property (p_deselect_float) else $error("pin driven while deselected");
    property p_read_end;
        @(posedge i_sys_clk) disable iff (i_rst)
        rd_q && cnt_q == 5'h18 && !i_sclk && !i_frame_select_n
        |-> o_sdio_oe && o_serial_out_pin_oe && !o_sdio && !o_serial_out_pin;
    endproperty
    a_read_end: assert property (p_read_end) else $error("pins not low after read");
    property p_wr_pulse;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_wr_valid |=> !o_wr_valid;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write event longer than a cycle");
    property p_wr_time;
        @(posedge i_sys_clk) disable iff (i_rst)
        $rose(wr_done) |-> ##[2:5] o_wr_valid;
    endproperty
    a_wr_time: assert property (p_wr_time) else $error("write event missing");
endmodule : srp_monitor
`default_nettype wire

//--- srp_host_model.sv
// host serial master: frames of a given clock count, serial clock only inside frames
// assumes the bench resolves the shared pin from both drivers
`timescale 1ns/1ps
`default_nettype none
module srp_host_model (
    // link drive
    output logic o_sclk,
    output logic o_frame_select_n,
    output logic o_sdio,
    // levels seen by the host
    input wire logic i_sdio,
    input wire logic i_serial_out_pin,
    input wire logic [3:0] i_pins
);
    initial begin
        o_sclk = 1'b0;
        o_frame_select_n = 1'b1;
        o_sdio = 1'b0;
    end
    // one frame; released data line toggles so no stale level remains
    task automatic frame(input logic [7:0] ins, input logic [15:0] wd, input logic four,
                         output logic [15:0] rd, output logic [3:0] fin, input int n);
        logic [23:0] sh;
        sh = {ins, wd};
        rd = 16'h0000;
        #7.2;
        o_frame_select_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            if (i < 8 || !ins[7])
                o_sdio <= sh[23-i];
            else
                o_sdio <= ~o_sdio;
            #15;
            if (i > 7)
                rd[23-i] = four ? i_serial_out_pin : i_sdio;
            o_sclk <= 1'b1;
            #15 o_sclk <= 1'b0;
        end
        #10 fin = i_pins;
        o_frame_select_n <= 1'b1;
        o_sdio <= ~o_sdio;
        #20;
    endtask : frame
endmodule : srp_host_model
`default_nettype wire

//--- tb_srp_serial_register_port.sv
// testbench: serial writes and reads in both wiring modes
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_srp_serial_register_port;
    logic i_sys_clk, i_rst, sclk, fsel_n, h_sdio, sdio_w, so_w;
    logic o_sdio, o_sdio_oe, o_serial_out_pin, o_serial_out_pin_oe, o_wr_valid, o_four_wire_select;
    srp_pkg::srp_addr_type i_rd_addr, o_wr_addr;
    srp_pkg::srp_word_type o_wr_data, o_rd_data;
    int err_count, n_tests, cyc;
    // wire levels: device wins, otherwise the host's changing level
    assign sdio_w = o_sdio_oe ? o_sdio : h_sdio;
    assign so_w = o_serial_out_pin_oe ? o_serial_out_pin : ~h_sdio;
    srp_serial_register_port DUT (.i_sys_clk, .i_rst, .i_sclk(sclk), .i_frame_select_n(fsel_n),
        .i_sdio(sdio_w), .o_sdio, .o_sdio_oe, .o_serial_out_pin, .o_serial_out_pin_oe,
        .o_wr_valid, .o_wr_addr, .o_wr_data, .i_rd_addr, .o_rd_data, .o_four_wire_select);
    srp_host_model host (.o_sclk(sclk), .o_frame_select_n(fsel_n), .o_sdio(h_sdio), .i_sdio(sdio_w),
        .i_serial_out_pin(so_w), .i_pins({o_sdio_oe, o_sdio, o_serial_out_pin_oe, o_serial_out_pin}));
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    // serial write, then the write event in the system domain
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] r;
        logic [3:0] f;
        int k;
        host.frame({1'b0, a}, d, 1'b0, r, f, 24);
        check("write pins", 16'h0000, {12'h000, f});
        k = 0;
        while (o_wr_valid !== 1'b1 && k < 20) begin
            @(posedge i_sys_clk);
            #1;
            k++;
        end
        check("write event", 16'h0001, {15'h0000, o_wr_valid});
        check("write addr", {9'h000, a}, {9'h000, o_wr_addr});
        check("write data", d, o_wr_data);
        @(posedge i_sys_clk);
        i_rd_addr <= a;
        repeat (2) @(posedge i_sys_clk);
        #1;
        check("mirror", d, o_rd_data);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic four, input logic [15:0] exp);
        logic [15:0] r;
        logic [3:0] f;
        host.frame({1'b1, a}, 16'h0000, four, r, f, 24);
        check("read data", exp, r);
        check("read end pins", 16'h000A, {12'h000, f});
    endtask : rd
    task automatic t_reset();
        check("four wire", 16'h0000, {15'h0000, o_four_wire_select});
        check("idle pins", 16'h0000, {12'h000, o_sdio_oe, o_sdio, o_serial_out_pin_oe, o_serial_out_pin});
        rd(7'h02, 1'b0, 16'h0000);
        $display("reset test done");
    endtask : t_reset
    task automatic t_three_wire();
        wr(7'h15, 16'hA53C);
        rd(7'h15, 1'b0, 16'hA53C);
        wr(7'h7F, 16'hFFFF);
        rd(7'h7F, 1'b0, 16'hFFFF);
        $display("three wire test done");
    endtask : t_three_wire
    // cut write frame: too few clocks, nothing stored or signalled
    task automatic t_cut();
        logic [15:0] r;
        logic [3:0] f;
        int seen;
        seen = 0;
        host.frame({1'b0, 7'h15}, 16'h1234, 1'b0, r, f, 20);
        repeat (8) begin
            @(posedge i_sys_clk);
            #1;
            if (o_wr_valid === 1'b1) begin
                seen++;
            end
        end
        check("cut write event", 16'h0000, seen[15:0]);
        rd(7'h15, 1'b0, 16'hA53C);
        $display("cut frame test done");
    endtask : t_cut
    task automatic t_four_wire();
        wr(7'h02, 16'h0001);
        repeat (6) @(posedge i_sys_clk);
        #1;
        check("four wire", 16'h0001, {15'h0000, o_four_wire_select});
        rd(7'h15, 1'b1, 16'hA53C);
        rd(7'h02, 1'b1, 16'h0001);
        wr(7'h02, 16'h0000);
        repeat (6) @(posedge i_sys_clk);
        #1;
        check("three wire", 16'h0000, {15'h0000, o_four_wire_select});
        rd(7'h7F, 1'b0, 16'hFFFF);
        $display("four wire test done");
    endtask : t_four_wire
    // hang guard
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        i_rst = 1'b1;
        i_rd_addr = 7'h00;
        err_count = 0;
        n_tests = 0;
        cyc = 0;
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        t_reset();
        t_three_wire();
        t_cut();
        t_four_wire();
        wrap_up();
    end
endmodule : tb_srp_serial_register_port
bind srp_serial_register_port srp_monitor mon (.i_sys_clk, .i_rst, .i_sclk, .i_frame_select_n,
    .i_sdio, .o_sdio, .o_sdio_oe, .o_serial_out_pin, .o_serial_out_pin_oe, .o_wr_valid,
    .o_four_wire_select);
`default_nettype wire
